// ===== verilog/isd_bitstream.sv
// digital model of an isolated second-order sigma-delta bitstream output
//
// Behaviour
// - one new output bit per rising clock while the filter holds bitReady high
// - single-bit quantizer in second-order loop
// - ones density equals (vin+clip)/(2*clip)
// - at negative clip: zeros, one every 128
// - at positive clip: ones, zero every 128
// - supply lost drives output constant low
// - common-mode overvoltage drives output constant high
// - supply loss wins over overvoltage
// - output valid after about 500 us startup
// - modulator runs on the same supplied clock
`timescale 1ns/1ps
`default_nettype none
module isd_bitstream
   import isd_pkg::*;
#(
   parameter int START_CYC = ISD_START_CYC   // analog startup, shorten in simulation
) (
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       rst_n,
   // analog side, sampled words and fault pins
   input  wire logic signed [ISD_IN_W-1:0] analogIn,    // analog_in_pos minus analog_in_neg
   input  wire logic                       supplyOk,    // high_side_supply present (pin)
   input  wire logic                       cmOverPin,   // beyond common_mode_overvoltage_threshold
   // bitstream towards the decimation filter
   output logic                            bitOut,      // serial bitstream
   output logic                            bitValid,    // a bit was launched this cycle
   input  wire logic                       bitReady,    // filter accepts bits
   output logic                            startDone    // startup elapsed and block in run mode, one cycle late
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] supSync;   // supply-present two-stage sync
   logic [1:0] cmSync;    // overvoltage two-stage sync
   // both fault pins come from the analog side across the barrier, so they are
   // asynchronous to mclk; a clean level costs two cycles of latency
   // reset values read as supply absent, so the output stays low at power-up
   // stage 0 feeds only stage 1; logic reads stage 1
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         supSync <= 2'h0;
         cmSync  <= 2'h0;
      end else begin
         supSync <= {supSync[0], supplyOk};
         cmSync  <= {cmSync[0], cmOverPin};
      end
   end
   isd_fault_t fault;     // synchronised fault levels
   assign fault.supplyLost = !supSync[1];
   assign fault.cmOver     = cmSync[1];

   // ------------------------------------------------------------
   // startup timer and state
   // ------------------------------------------------------------
   localparam int SW = $clog2(START_CYC + 1);
   logic [SW-1:0] startCnt;       // cycles since supply came up
   isd_state_t    state;          // block mode
   isd_state_t    next_state;
   wire           startFull = (startCnt == SW'(START_CYC));
   // the timer stands in for the analog settling time; it stops at full, so
   // startFull stays a plain level while the modulator runs
   // timer restarts whenever the supply is lost, since analog must settle again
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         startCnt <= '0;
      end else if (fault.supplyLost) begin
         startCnt <= '0;
      end else if (!startFull) begin
         startCnt <= startCnt + 1'b1;
      end
   end
   // mode selection: supply loss first, then overvoltage
   always_comb begin
      case (state)
         ISD_ST_START: next_state = fault.supplyLost ? ISD_ST_FAULT :
                                    startFull ? ISD_ST_RUN : ISD_ST_START;
         ISD_ST_RUN:   next_state = (fault.supplyLost || fault.cmOver) ? ISD_ST_FAULT
                                                                         : ISD_ST_RUN;
         ISD_ST_FAULT: next_state = fault.supplyLost ? ISD_ST_FAULT :
                                    fault.cmOver ? ISD_ST_FAULT : ISD_ST_START;
         default:      next_state = ISD_ST_START;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) state <= ISD_ST_START;
      else        state <= next_state;
   end

   // ------------------------------------------------------------
   // second-order modulator loop
   // ------------------------------------------------------------
   // loop: i1 += x - y, i2 += i1 - y, y = sign(i2); this gives a signal
   // transfer of one and a noise transfer of (1 - z^-1)^2
   // limitation: a one-bit second-order loop loses stability close to the
   // clip level, so inputs just inside it may show extra tones
   // integrators carry four spare bits so the loop never wraps in range
   // both integrators share mclk, so sampling stays locked to the output bits
   logic signed [ISD_ACC_W-1:0] integ1;   // first integrator
   logic signed [ISD_ACC_W-1:0] integ2;   // second integrator
   logic                        quantBit; // last quantizer decision
   wire signed [ISD_ACC_W-1:0]  inExt  = ISD_ACC_W'(analogIn);
   wire signed [ISD_ACC_W-1:0]  fb     = quantBit ? ISD_FB_POS : ISD_FB_NEG;
   wire signed [ISD_ACC_W-1:0]  next_i1 = integ1 + inExt - fb;
   wire signed [ISD_ACC_W-1:0]  next_i2 = integ2 + next_i1 - fb;
   wire                         next_q  = !next_i2[ISD_ACC_W-1];  // one comparator
   wire                         clipPos = (analogIn >= ISD_CLIP_CODE);
   wire                         clipNeg = (analogIn <= -ISD_CLIP_CODE);
   wire                         running = (state == ISD_ST_RUN);
   // loop held in reset outside run, so it restarts clean after a fault
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         integ1   <= ISD_ACC_RST;
         integ2   <= ISD_ACC_RST;
         quantBit <= 1'b0;
      end else if (!running || clipPos || clipNeg) begin
         integ1   <= ISD_ACC_RST;
         integ2   <= ISD_ACC_RST;
         quantBit <= 1'b0;
      end else begin
         integ1   <= next_i1;
         integ2   <= next_i2;
         quantBit <= next_q;
      end
   end

   // ------------------------------------------------------------
   // clip marker counter
   // ------------------------------------------------------------
   // never held or cleared by mode changes, so the marker phase stays fixed
   // and a decimator can lock on it
   logic [6:0] markCnt;           // free-running, wraps every 128 clocks
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) markCnt <= ISD_MARK_RST;
      else        markCnt <= markCnt + 7'h01;
   end
   wire markNow = (markCnt == ISD_MARK_LAST);

   // ------------------------------------------------------------
   // output bit selection
   // ------------------------------------------------------------
   // the fail-safe levels bypass the mode so they reach the pin even while
   // the startup timer runs
   // priority: supply loss low, overvoltage high, clipping, modulator
   wire runBit  = clipPos ? !markNow :
                  clipNeg ? markNow :
                  next_q;
   wire next_bit = fault.supplyLost ? 1'b0 :
                   fault.cmOver ? 1'b1 :
                   running ? runBit : 1'b0;
   // the stream buffer decouples a stalling filter from the bit clock
   logic fifoReady;               // buffer can take a bit
   logic fifoValid;
   logic fifoBit;
   isd_fifo #(
      .WIDTH (ISD_FIFO_W),
      .DEPTH (ISD_FIFO_D)
   ) u_fifo (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .inValid  (1'b1),
      .inReady  (fifoReady),
      .inData   (next_bit),
      .outValid (fifoValid),
      .outReady (bitReady),
      .outData  (fifoBit)
   );
   wire  popNow = fifoValid && bitReady;   // a bit leaves the buffer this edge
   // at most one bit launched per rising edge, only on a pop; a full buffer drops the new bit
   // bitOut only moves on a pop, so it never shows an unwritten buffer slot
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bitOut    <= 1'b0;
         bitValid  <= 1'b0;
         startDone <= 1'b0;
      end else begin
         if (popNow) begin
            bitOut <= fifoBit;
         end
         bitValid  <= popNow;
         startDone <= running;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // all properties sample on mclk and stay quiet while reset is held
   // supply loss reaches the fault mode on the next edge
   property p_supply_low;
      @(posedge mclk) disable iff (!rst_n)
      fault.supplyLost |=> (state == ISD_ST_FAULT) && !running;
   endproperty
   a_supply_low: assert property (p_supply_low) else $error("supply loss not forcing fault");
   // both faults at once: the low level wins
   property p_supply_prio;
      @(posedge mclk) disable iff (!rst_n)
      (fault.supplyLost && fault.cmOver) |-> !next_bit;
   endproperty
   a_supply_prio: assert property (p_supply_prio) else $error("overvoltage beat supply loss");
   // overvoltage alone forces a high level
   property p_cm_high;
      @(posedge mclk) disable iff (!rst_n)
      (!fault.supplyLost && fault.cmOver) |-> next_bit;
   endproperty
   a_cm_high: assert property (p_cm_high) else $error("overvoltage not high");
   // negative clip: zeros with the marker one
   property p_mark_neg;
      @(posedge mclk) disable iff (!rst_n)
      (running && clipNeg && !fault.supplyLost && !fault.cmOver) |-> (next_bit == markNow);
   endproperty
   a_mark_neg: assert property (p_mark_neg) else $error("negative clip marker wrong");
   // positive clip: ones with the marker zero
   property p_mark_pos;
      @(posedge mclk) disable iff (!rst_n)
      (running && clipPos && !fault.supplyLost && !fault.cmOver) |-> (next_bit != markNow);
   endproperty
   a_mark_pos: assert property (p_mark_pos) else $error("positive clip marker wrong");
   // no second marker in the eight clocks after a marker
   property p_mark_period;
      @(posedge mclk) disable iff (!rst_n)
      markNow |=> !markNow [*8];
   endproperty
   a_mark_period: assert property (p_mark_period) else $error("marker repeats too soon");
   // no run before the startup timer is full
   property p_start_wait;
      @(posedge mclk) disable iff (!rst_n)
      (state == ISD_ST_START && !startFull) |=> !running;
   endproperty
   a_start_wait: assert property (p_start_wait) else $error("ran before startup");
   // every pop shows on the pins one edge later
   property p_launch;
      @(posedge mclk) disable iff (!rst_n)
      (fifoValid && bitReady) |=> bitValid && (bitOut == $past(fifoBit));
   endproperty
   a_launch: assert property (p_launch) else $error("bit not launched");
   // each unclipped run cycle yields exactly one quantizer decision
   property p_one_decision;
      @(posedge mclk) disable iff (!rst_n)
      (running && !clipPos && !clipNeg) |=> (quantBit == !$past(next_i2[ISD_ACC_W-1]));
   endproperty
   a_one_decision: assert property (p_one_decision) else $error("quantizer decision lost");

   // startDone mirrors the run mode one cycle late
   property p_start_flag;
      @(posedge mclk) disable iff (!rst_n)
      1'b1 |=> (startDone == $past(running));
   endproperty
   a_start_flag: assert property (p_start_flag) else $error("startDone off");

   // a full timer in the start mode enters run on the next edge
   property p_run_entry;
      @(posedge mclk) disable iff (!rst_n)
      (state == ISD_ST_START && startFull && !fault.supplyLost) |=> running;
   endproperty
   a_run_entry: assert property (p_run_entry) else $error("run not entered");

   // a supply loss restarts the settling time
   property p_start_clear;
      @(posedge mclk) disable iff (!rst_n)
      fault.supplyLost |=> (startCnt == '0);
   endproperty
   a_start_clear: assert property (p_start_clear) else $error("startup timer kept");

   // overvoltage keeps the block in the fault mode
   property p_cm_hold;
      @(posedge mclk) disable iff (!rst_n)
      (state == ISD_ST_FAULT && fault.cmOver) |=> (state == ISD_ST_FAULT);
   endproperty
   a_cm_hold: assert property (p_cm_hold) else $error("fault left under overvoltage");

   // the marker counter wraps straight after the marker count
   property p_mark_wrap;
      @(posedge mclk) disable iff (!rst_n)
      markNow |=> (markCnt == ISD_MARK_RST);
   endproperty
   a_mark_wrap: assert property (p_mark_wrap) else $error("marker counter not wrapping");

   // without faults the stream stays low until the modulator runs
   property p_idle_low;
      @(posedge mclk) disable iff (!rst_n)
      (!running && !fault.supplyLost && !fault.cmOver) |-> !next_bit;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("output not low at startup");

   // clipping holds the loop cleared, so it restarts clean in range
   property p_clip_hold;
      @(posedge mclk) disable iff (!rst_n)
      (clipPos || clipNeg) |=> (integ1 == ISD_ACC_RST) && (integ2 == ISD_ACC_RST);
   endproperty
   a_clip_hold: assert property (p_clip_hold) else $error("loop not held in clip");

   // no pop: no new bit and the pin keeps its level
   property p_no_pop;
      @(posedge mclk) disable iff (!rst_n)
      !popNow |=> !bitValid && $stable(bitOut);
   endproperty
   a_no_pop: assert property (p_no_pop) else $error("bit launched without pop");

   // a full buffer stays full while the filter stalls
   property p_full_stall;
      @(posedge mclk) disable iff (!rst_n)
      (!fifoReady && !bitReady) |=> !fifoReady;
   endproperty
   a_full_stall: assert property (p_full_stall) else $error("buffer drained in stall");
endmodule
`default_nettype wire

// ===== verilog/isd_pkg.sv
// package of constants and carrier types for the isolated sigma-delta bitstream block
package isd_pkg;
   // ------------------------------------------------------------
   // input word format
   // ------------------------------------------------------------
   localparam int          ISD_IN_W        = 16;        // signed differential input width
   localparam int          ISD_ACC_W       = 20;        // integrator width, headroom for 2nd order
   // clip level as a signed input code (0x7000, 7/8 of the input word's full scale, stands for +-clip_level)
   localparam logic signed [15:0] ISD_CLIP_CODE = 16'sh7000;
   localparam logic signed [19:0] ISD_FB_POS    = 20'sh07000; // quantizer feedback, +clip
   localparam logic signed [19:0] ISD_FB_NEG    = -20'sh07000; // quantizer feedback, -clip
   localparam logic signed [19:0] ISD_ACC_RST   = 20'sh00000; // integrator value after reset
   // ------------------------------------------------------------
   // marker and timing
   // ------------------------------------------------------------
   localparam int          ISD_MARK_PERIOD = 128;       // clocks between clipped-stream markers
   localparam logic [6:0]  ISD_MARK_RST    = 7'h00;     // marker counter value after reset
   localparam logic [6:0]  ISD_MARK_LAST   = 7'h7F;     // count at which the marker bit goes out
   localparam int          ISD_CLK_HZ      = 10_000_000; // mclk rate
   localparam int          ISD_START_US    = 500;       // analog startup time, microseconds
   localparam int          ISD_START_CYC   = ISD_START_US * (ISD_CLK_HZ / 1_000_000);
   localparam int          ISD_FIFO_W      = 1;         // one bit per stream word
   localparam int          ISD_FIFO_D      = 8;         // stream buffer depth
   // ------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic supplyLost;    // high-side supply absent
      logic cmOver;        // common-mode beyond overvoltage threshold
   } isd_fault_t;
   typedef enum logic [1:0] {
      ISD_ST_START = 2'b00,   // waiting for analog startup
      ISD_ST_RUN   = 2'b01,   // normal modulation
      ISD_ST_FAULT = 2'b11    // fail-safe level forced
   } isd_state_t;
endpackage

// ===== verilog/isd_fifo.sv
// parameterised valid/ready stream buffer
`timescale 1ns/1ps
`default_nettype none
module isd_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             inValid,
   output var  logic             inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output var  logic             outValid,
   input  wire logic             outReady,
   output var  logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   // ------------------------------------------------------------
   // storage and pointers
   // ------------------------------------------------------------
   logic [WIDTH-1:0] mem [DEPTH];    // word store
   logic [AW-1:0]    wrPtr;          // next write slot
   logic [AW-1:0]    rdPtr;          // next read slot
   logic [AW:0]      count;          // words held
   wire              doWrite = inValid && inReady;
   wire              doRead  = outValid && outReady;
   // honest flags straight from the count
   assign inReady  = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData  = mem[rdPtr];
   // write port, memory holds no reset
   always_ff @(posedge mclk) begin
      if (doWrite) begin
         mem[wrPtr] <= inData;
      end
   end
   // pointers wrap at depth
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doWrite) wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         if (doRead)  rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
      end
   end
endmodule
`default_nettype wire

// ===== test/isd_filter_model.sv
// stand-in for the decimation filter that tallies the stream
`timescale 1ns/1ps
`default_nettype none
module isd_filter_model (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // stream from the device
   input  wire logic        bitOut,
   input  wire logic        bitValid,
   output logic             bitReady,
   // bench control and tallies
   input  wire logic        stall,
   input  wire logic        clr,
   output logic [15:0]      bits,
   output logic [15:0]      ones
);
   // ------------------------------------------------------------
   // ready and stream tallies
   // ------------------------------------------------------------
   // ready moves just after the rising edge, so the device never races it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bitReady <= 1'b0;
         bits     <= 16'h0000;
         ones     <= 16'h0000;
      end else begin
         bitReady <= !stall;
         if (clr) begin // clear wins so a window starts clean
            bits <= 16'h0000;
            ones <= 16'h0000;
         end else if (bitValid) begin
            // one stream bit per pop
            bits <= bits + 16'h0001;
            ones <= ones + {15'h0000, bitOut};
         end
      end
   end
endmodule
`default_nettype wire

// ===== test/isolated_sd_bitstream_output_tb.sv
// self-checking bench for the sigma-delta bitstream block
`timescale 1ns/1ps
`default_nettype none
module isolated_sd_bitstream_output_tb;
   import isd_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int START = 20;             // short startup for simulation
   logic                       mclk;      // 10 MHz clock
   logic                       rst_n;     // async reset
   logic signed [ISD_IN_W-1:0] analogIn;  // input word
   logic                       supplyOk;  // supply present
   logic                       cmOverPin; // overvoltage flag
   logic                       stall;     // ask the filter to stall
   logic                       clr;       // clear filter tallies
   logic                       bitOut;
   logic                       bitValid;
   logic                       bitReady;
   logic                       startDone;
   logic [15:0]                bits;
   logic [15:0]                ones;
   int                         mismatches;
   int                         total_checks;
   int                         idx;
   int                         last;
   // rows: input word and bounds on ones in 256 bits
   logic signed [15:0] rowIn [7] = '{16'sh0000, 16'sh3800, -16'sh3800, 16'sh7000,
                                     16'sh7FFF, -16'sh7000, 16'sh8000};
   logic [15:0]        rowLo [7] = '{16'h007D, 16'h00BD, 16'h003D, 16'h00FE,
                                     16'h00FE, 16'h0002, 16'h0002};
   logic [15:0]        rowHi [7] = '{16'h0083, 16'h00C3, 16'h0043, 16'h00FE,
                                     16'h00FE, 16'h0002, 16'h0002};
   // fault cases: supply, overvoltage, ones expected in 32 bits
   logic        fSup [3] = '{1'b0, 1'b1, 1'b0};
   logic        fCm  [3] = '{1'b0, 1'b1, 1'b1};
   logic [15:0] fOnes[3] = '{16'h0000, 16'h0020, 16'h0000};
   // ------------------------------------------------------------
   // instances
   // ------------------------------------------------------------
   isd_bitstream #(.START_CYC(START)) uut (.mclk(mclk), .rst_n(rst_n), .analogIn(analogIn),
      .supplyOk(supplyOk), .cmOverPin(cmOverPin), .bitOut(bitOut), .bitValid(bitValid),
      .bitReady(bitReady), .startDone(startDone));
   isd_filter_model filt (.mclk(mclk), .rst_n(rst_n), .bitOut(bitOut), .bitValid(bitValid),
      .bitReady(bitReady), .stall(stall), .clr(clr), .bits(bits), .ones(ones));
   // 50 percent duty at 10 MHz, inside the allowed rate and duty window
   always #50 mclk = ~mclk;
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic clear();
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
   endtask
   // gather n bits; a stuck stream ends the run
   task automatic collect(input int n);
      int i;
      clear();
      for (i = 0; i < 4 * n + 50 && bits != n; i++) tick(1);
      if (bits != n) begin
         mismatches++;
         wrap_up();
      end
   endtask
   task automatic wait_start();
      int i;
      for (i = 0; i < START + 40 && startDone !== 1'b1; i++) tick(1);
      check("startDone", startDone, 1'b1);
      if (startDone !== 1'b1) wrap_up();
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0; rst_n = 1'b0; analogIn = 16'sh0000; supplyOk = 1'b1;
      cmOverPin = 1'b0; stall = 1'b0; clr = 1'b0;
      mismatches = 0; total_checks = 0;
      tick(3);
      check("valid in reset", bitValid, 1'b0);
      check("start in reset", startDone, 1'b0);
      rst_n = 1'b1;
      tick(4);
      check("early start", startDone, 1'b0);
      wait_start();
      // one new bit on every clock while the filter keeps up
      clear();
      tick(50);
      check("bits per clock", bits, 16'h0032);
      // density rows, settling the loop before each window
      for (int r = 0; r < 7; r++) begin
         analogIn = rowIn[r];
         collect(64);
         collect(256);
         check("density", ones >= rowLo[r] && ones <= rowHi[r], 1'b1);
      end
      // marker spacing at the positive clip
      analogIn = 16'sh7000;
      tick(4); // flush bits computed before the switch out of the buffer
      idx = 0; last = -1;
      for (int c = 0; c < 600 && idx < 400; c++) begin
         tick(1);
         if (bitValid === 1'b1) begin
            idx++;
            if (bitOut === 1'b0) begin
               if (last >= 0) check("marker gap", 16'(idx - last), 16'h0080);
               last = idx;
            end
         end
      end
      check("marker seen", last > 0, 1'b1);
      // fail-safe levels and their priority
      analogIn = 16'sh0000;
      for (int k = 0; k < 3; k++) begin
         supplyOk = fSup[k];
         cmOverPin = fCm[k];
         collect(16);
         collect(32);
         check("fail-safe ones", ones, fOnes[k]);
         check("start in fault", startDone, 1'b0);
      end
      supplyOk = 1'b1;
      cmOverPin = 1'b0;
      tick(4);
      check("restart early", startDone, 1'b0);
      wait_start();
      // stalled filter: no pops, then the stored words drain back to back
      stall = 1'b1;
      tick(3);
      clear();
      tick(10);
      check("stalled pops", bits, 16'h0000);
      stall = 1'b0;
      clear();
      tick(20);
      check("drain count", bits >= 16'h0011 && bits <= 16'h0014, 1'b1);
      // second reset in mid-run
      rst_n = 1'b0;
      tick(2);
      check("valid in reset", bitValid, 1'b0);
      check("out in reset", bitOut, 1'b0);
      check("start in reset", startDone, 1'b0);
      rst_n = 1'b1;
      wait_start();
      wrap_up();
   end
endmodule
`default_nettype wire
